// ---- verilog/fcm_pkg.sv ----
// constants and carrier types for the float convert, mode and status unit
package fcm_pkg;
  // status word layout
  localparam int PREC_BIT = 7;
  localparam int LONG_BIT = 6;
  localparam int TRUNC_BIT = 5;
  localparam int FLAGS_LSB = 0;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // float word layout: sign, excess-128 exponent, hidden-bit fraction
  localparam int SIGN_BIT = 63;
  localparam int EXP_HI = 62;
  localparam int EXP_LO = 55;
  localparam logic [7:0] EXP_BIAS = 8'h80;
  localparam logic [7:0] EXP_ONE = 8'h01;
  localparam logic [7:0] INT_MAX_SHIFT = 8'h20;
  // largest integers for the range check
  localparam logic [31:0] INT_LIMIT_SHORT = 32'h0000_7fff;
  localparam logic [31:0] INT_LIMIT_LONG = 32'h7fff_ffff;
  // destination word counts
  localparam logic [2:0] WORDS_NONE = 3'h0;
  localparam logic [2:0] WORDS_ONE = 3'h1;
  localparam logic [2:0] WORDS_TWO = 3'h2;
  localparam logic [2:0] WORDS_FOUR = 3'h4;
  localparam logic [3:0] EXC_CODE_RST = 4'h0;
  localparam logic [15:0] EXC_ADDR_RST = 16'h0000;

  typedef enum logic [3:0] {
    OP_CONV_STORE,
    OP_INT_LOAD,
    OP_INT_STORE,
    OP_EXP_LOAD,
    OP_EXP_STORE,
    OP_CLEAR,
    OP_MAGNITUDE,
    OP_FLAG_TEST,
    OP_SINGLE_MODE,
    OP_DOUBLE_MODE,
    OP_SHORT_INT_MODE,
    OP_LONG_INT_MODE,
    OP_STATUS_LOAD,
    OP_STATUS_STORE,
    OP_EXCEPTION_STORE,
    OP_FLAG_COPY
  } fcm_op_t;

  typedef struct packed {
    fcm_op_t op;
    logic dst_reg;
    logic [31:0] src;
    logic [63:0] float_dest;
    logic [63:0] acc;
  } fcm_cmd_t;

  typedef struct packed {
    logic dst_wr;
    logic [2:0] dst_words;
    logic [63:0] dst_val;
    logic acc_wr;
    logic [63:0] acc_val;
  } fcm_res_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } fcm_cc_t;
endpackage : fcm_pkg

// ---- verilog/fcm_lead_norm.sv ----
// leading-one finder and left normaliser for integer magnitudes
module fcm_lead_norm (
  input wire logic [31:0] mag_i, // unsigned magnitude
  output logic [31:0] norm_o,    // magnitude with leading one at bit 31
  output logic [4:0] pos_o,      // position of the leading one
  output logic zero_o            // magnitude is zero
);
  always_comb begin
    pos_o = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag_i[i]) begin
        pos_o = 5'(i);
      end
    end
    norm_o = mag_i << (5'h1f - pos_o);
    zero_o = (mag_i == 32'h0000_0000);
  end
endmodule : fcm_lead_norm

// ---- verilog/fcm_convert_unit.sv ----
// float convert, exponent, mode and status execution unit
// Overview of operation
// - single mode convert-store: value left aligned, lower half zero
// - double mode convert-store: reduce to single, truncate or round by mode
// - integer load: two's complement, 16 or 32 bits, result in current precision
// - long mode, register or immediate source: 16 bits upper, lower zeroed
// - 32-bit integer to single: keep only 24 most significant bits
// - long store to register or immediate: write only upper 16 bits
// - float-to-integer out of range: carry set, destination zero
// - float-to-integer always truncates, ignoring truncate mode
// - exponent load: sign kept, exponent is source plus 200 octal
// - exponent store: exponent minus 200 octal, two's complement
// - exponent store: clear C and V, set Z and N, both flag sets
// - magnitude: destination replaced by its absolute value in place
// - test: operand untouched, set Z and N, clear C and V
// - single mode clears precision bit, double mode sets it
// - short integer mode clears long bit, long mode sets it
// - status load copies source into status register
// - status store writes status register to destination
// - exception store: code first, address in following word
// - exception store to register or immediate: code only
// - flag copy moves float C, V, Z, N to CPU flags
// - integer limit is 2^15-1 short, 2^31-1 long
module fcm_convert_unit
  import fcm_pkg::*;
(
  input wire logic sys_clk,              // unit clock
  input wire logic rst_b,                // async reset, active low
  input wire logic cmd_valid,            // command strobe
  input wire fcm_pkg::fcm_cmd_t cmd_i,   // command and operands
  input wire logic exc_set,              // arithmetic side records an exception
  input wire logic [3:0] exc_code_in,    // exception code to record
  input wire logic [15:0] exc_addr_in,   // exception address to record
  output logic res_valid,                // result strobe
  output fcm_pkg::fcm_res_t res,         // result words
  output logic [15:0] fp_status,         // status register
  output fcm_pkg::fcm_cc_t cpu_cc,       // CPU condition flags
  output logic cpu_cc_wr                 // CPU flags updated
);
  import fcm_pkg::*;

  logic res_valid_q;
  fcm_res_t res_q;
  fcm_res_t res_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  fcm_cc_t cpu_cc_q;
  fcm_cc_t cc_d;
  logic cpu_wr_q;
  logic cpu_wr_d;
  logic [3:0] exc_code_q;
  logic [15:0] exc_addr_q;

  logic dbl;
  logic lng;
  logic trunc;
  logic [63:0] acc;
  logic [63:0] fdest;
  logic [2:0] fmt_words;

  assign acc = cmd_i.acc;
  assign fdest = cmd_i.float_dest;
  assign dbl = status_q[PREC_BIT];
  assign lng = status_q[LONG_BIT];
  assign trunc = status_q[TRUNC_BIT];
  assign fmt_words = dbl ? WORDS_FOUR : WORDS_TWO;

  // accumulator and destination classification
  logic acc_zero;
  logic acc_neg;
  logic dst_zero;
  assign acc_zero = (acc[EXP_HI:EXP_LO] == 8'h00);
  assign acc_neg = acc[SIGN_BIT] & ~acc_zero;
  assign dst_zero = (fdest[EXP_HI:EXP_LO] == 8'h00);

  // double to single reduction
  logic [31:0] rnd_sum;
  logic [31:0] rnd_single;
  logic rnd_ovf;
  assign rnd_sum = {1'b0, acc[62:32]} + {31'h0000_0000, acc[31] & ~trunc};
  assign rnd_ovf = rnd_sum[31];
  assign rnd_single = {acc[SIGN_BIT], rnd_sum[30:0]};

  // integer to float
  logic [31:0] ld_int;
  logic ld_neg;
  logic [31:0] ld_mag;
  logic [31:0] ld_norm;
  logic [4:0] ld_pos;
  logic ld_zero;
  logic [54:0] ld_frac;
  logic [7:0] ld_exp;
  logic [63:0] ld_val;

  always_comb begin
    if (!lng) begin
      ld_int = {{16{cmd_i.src[15]}}, cmd_i.src[15:0]};
    end else if (cmd_i.dst_reg) begin
      ld_int = {cmd_i.src[15:0], 16'h0000};
    end else begin
      ld_int = cmd_i.src;
    end
  end

  assign ld_neg = ld_int[31];
  assign ld_mag = ld_neg ? 32'(-ld_int) : ld_int;

  fcm_lead_norm u_norm (
    .mag_i(ld_mag),
    .norm_o(ld_norm),
    .pos_o(ld_pos),
    .zero_o(ld_zero)
  );

  // single keeps the 24 leading bits only, the rest is dropped
  assign ld_frac = dbl ? {ld_norm[30:0], 24'h00_0000} : {ld_norm[30:8], 32'h0000_0000};
  assign ld_exp = EXP_BIAS + EXP_ONE + {3'h0, ld_pos};
  assign ld_val = ld_zero ? 64'h0000_0000_0000_0000 : {ld_neg, ld_exp, ld_frac};

  // float to integer, always truncating
  logic [7:0] f_shift;
  logic f_small;
  logic f_big;
  logic [32:0] f_mant;
  logic [32:0] f_mag;
  logic [31:0] f_lim;
  logic f_oor;
  logic [31:0] f_int;
  logic [31:0] st_val;
  logic st_zero;
  logic st_neg;

  assign f_shift = acc[EXP_HI:EXP_LO] - EXP_BIAS;
  assign f_small = acc[EXP_HI:EXP_LO] <= EXP_BIAS;
  assign f_big = ~f_small & (f_shift > INT_MAX_SHIFT);
  assign f_mant = dbl ? {1'b1, acc[54:23]} : {1'b1, acc[54:32], 9'h000};
  // bits below the binary point fall away: no rounding here
  assign f_mag = f_mant >> (6'h21 - f_shift[5:0]);
  assign f_lim = lng ? INT_LIMIT_LONG : INT_LIMIT_SHORT;
  assign f_oor = ~f_small & (f_big | (f_mag > ({1'b0, f_lim} + {32'h0000_0000, acc[SIGN_BIT]})));
  always_comb begin
    if (f_small || f_oor) begin
      f_int = 32'h0000_0000;
    end else if (acc[SIGN_BIT]) begin
      f_int = 32'(-f_mag[31:0]);
    end else begin
      f_int = f_mag[31:0];
    end
  end
  assign st_val = (lng && cmd_i.dst_reg) ? {{16{f_int[31]}}, f_int[31:16]} :
                  (lng ? f_int : {{16{f_int[15]}}, f_int[15:0]});
  assign st_zero = (st_val == 32'h0000_0000);
  assign st_neg = st_val[31];

  // exponent load and store
  logic [7:0] le_exp;
  logic [7:0] se_val;
  assign le_exp = cmd_i.src[7:0] + EXP_BIAS;
  assign se_val = acc[EXP_HI:EXP_LO] - EXP_BIAS;

  always_comb begin
    res_d = '0;
    cc_d = status_q[FLAGS_LSB +: 4];
    cpu_wr_d = 1'b0;
    status_d = status_q;
    case (cmd_i.op)
      OP_CONV_STORE: begin
        res_d.dst_wr = 1'b1;
        if (!dbl) begin
          res_d.dst_val = {acc[63:32], 32'h0000_0000};
          res_d.dst_words = WORDS_FOUR;
        end else begin
          res_d.dst_val = {32'h0000_0000, rnd_single};
          res_d.dst_words = WORDS_TWO;
        end
        cc_d = '{n: acc_neg, z: acc_zero, v: dbl & rnd_ovf, c: 1'b0};
      end
      OP_INT_LOAD: begin
        res_d.acc_wr = 1'b1;
        res_d.acc_val = ld_val;
        cc_d = '{n: ~ld_zero & ld_neg, z: ld_zero, v: 1'b0, c: 1'b0};
      end
      OP_INT_STORE: begin
        res_d.dst_wr = 1'b1;
        res_d.dst_words = (lng && !cmd_i.dst_reg) ? WORDS_TWO : WORDS_ONE;
        res_d.dst_val = {32'h0000_0000, st_val};
        cc_d = '{n: st_neg, z: st_zero, v: 1'b0, c: f_oor};
        cpu_wr_d = 1'b1;
      end
      OP_EXP_LOAD: begin
        res_d.acc_wr = 1'b1;
        res_d.acc_val = {acc[SIGN_BIT], le_exp, acc[54:0]};
        cc_d = '{n: acc[SIGN_BIT] & (le_exp != 8'h00), z: le_exp == 8'h00, v: 1'b0, c: 1'b0};
      end
      OP_EXP_STORE: begin
        res_d.dst_wr = 1'b1;
        res_d.dst_words = WORDS_ONE;
        res_d.dst_val = {48'h0000_0000_0000, {8{se_val[7]}}, se_val};
        cc_d = '{n: se_val[7], z: se_val == 8'h00, v: 1'b0, c: 1'b0};
        cpu_wr_d = 1'b1;
      end
      OP_CLEAR: begin
        res_d.dst_wr = 1'b1;
        res_d.dst_words = fmt_words;
        cc_d = '{n: 1'b0, z: 1'b1, v: 1'b0, c: 1'b0};
      end
      OP_MAGNITUDE: begin
        res_d.dst_wr = 1'b1;
        res_d.dst_words = fmt_words;
        res_d.dst_val = dbl ? {1'b0, fdest[62:0]} : {32'h0000_0000, 1'b0, fdest[62:32]};
        cc_d = '{n: 1'b0, z: dst_zero, v: 1'b0, c: 1'b0};
      end
      OP_FLAG_TEST: begin
        cc_d = '{n: fdest[SIGN_BIT] & ~dst_zero, z: dst_zero, v: 1'b0, c: 1'b0};
      end
      OP_SINGLE_MODE: begin
        status_d[PREC_BIT] = 1'b0;
      end
      OP_DOUBLE_MODE: begin
        status_d[PREC_BIT] = 1'b1;
      end
      OP_SHORT_INT_MODE: begin
        status_d[LONG_BIT] = 1'b0;
      end
      OP_LONG_INT_MODE: begin
        status_d[LONG_BIT] = 1'b1;
      end
      OP_STATUS_LOAD: begin
        status_d = cmd_i.src[15:0];
        cc_d = cmd_i.src[FLAGS_LSB +: 4];
      end
      OP_STATUS_STORE: begin
        res_d.dst_wr = 1'b1;
        res_d.dst_words = WORDS_ONE;
        res_d.dst_val = {48'h0000_0000_0000, status_q};
      end
      OP_EXCEPTION_STORE: begin
        res_d.dst_wr = 1'b1;
        res_d.dst_words = cmd_i.dst_reg ? WORDS_ONE : WORDS_TWO;
        res_d.dst_val = {32'h0000_0000, exc_addr_q, 12'h000, exc_code_q};
      end
      OP_FLAG_COPY: begin
        cpu_wr_d = 1'b1;
      end
      default: begin
        res_d = '0;
      end
    endcase
    if (cmd_i.op != OP_STATUS_LOAD) begin
      status_d[FLAGS_LSB +: 4] = cc_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid_q <= 1'b0;
      res_q <= '0;
    end else begin
      res_valid_q <= cmd_valid;
      res_q <= cmd_valid ? res_d : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= STATUS_RST;
    end else if (cmd_valid) begin
      status_q <= status_d;
    end
  end

  // CPU flags mirror the float flags after the update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_cc_q <= '0;
      cpu_wr_q <= 1'b0;
    end else begin
      cpu_wr_q <= cmd_valid & cpu_wr_d;
      if (cmd_valid && cpu_wr_d) begin
        cpu_cc_q <= status_d[FLAGS_LSB +: 4];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      exc_code_q <= EXC_CODE_RST;
      exc_addr_q <= EXC_ADDR_RST;
    end else if (exc_set) begin
      exc_code_q <= exc_code_in;
      exc_addr_q <= exc_addr_in;
    end
  end

  assign res_valid = res_valid_q;
  assign res = res_q;
  assign fp_status = status_q;
  assign cpu_cc = cpu_cc_q;
  assign cpu_cc_wr = cpu_wr_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_issue(fcm_op_t o);
    cmd_valid && cmd_i.op == o;
  endsequence

  a_single_store_fill: assert property (s_issue(OP_CONV_STORE) ##0 !dbl |=>
    res.dst_val[31:0] == 32'h0000_0000 && res.dst_words == WORDS_FOUR)
    else $error("single convert-store lower half not zero");
  a_double_store_cut: assert property (s_issue(OP_CONV_STORE) ##0 dbl && trunc |=>
    res.dst_val[31:0] == $past(acc[63:32]) && res.dst_words == WORDS_TWO)
    else $error("truncated convert-store wrong");
  a_int_load_sign: assert property (s_issue(OP_INT_LOAD) ##0 !ld_zero |=>
    res.acc_val[SIGN_BIT] == $past(ld_int[31]) && res.acc_wr)
    else $error("integer load sign wrong");
  a_long_reg_place: assert property (s_issue(OP_INT_LOAD) ##0 lng && cmd_i.dst_reg
    && cmd_i.src[15:0] == 16'h0001 |=> res.acc_val[EXP_HI:EXP_LO] == 8'h91)
    else $error("register source not placed in upper half");
  a_single_frac_cut: assert property (s_issue(OP_INT_LOAD) ##0 !dbl |=>
    res.acc_val[31:0] == 32'h0000_0000)
    else $error("single integer load kept low bits");
  a_long_reg_upper: assert property (s_issue(OP_INT_STORE) ##0 lng && cmd_i.dst_reg |=>
    res.dst_words == WORDS_ONE && res.dst_val[15:0] == $past(f_int[31:16]))
    else $error("long store to register wrong");
  a_range_zero: assert property (s_issue(OP_INT_STORE) ##0 f_oor |=>
    fp_status[FLAGS_LSB] && res.dst_val == 64'h0000_0000_0000_0000 && cpu_cc.c)
    else $error("out of range store not flagged");
  a_exp_bias: assert property (s_issue(OP_EXP_STORE) |=>
    res.dst_val[7:0] == 8'($past(acc[EXP_HI:EXP_LO]) - EXP_BIAS) && cpu_cc_wr)
    else $error("exponent store bias wrong");
  a_test_flags: assert property (s_issue(OP_FLAG_TEST) |=>
    !res.dst_wr && fp_status[1:0] == 2'h0)
    else $error("test wrote or left C/V");
  a_mode_bits: assert property (s_issue(OP_SINGLE_MODE) |=> !fp_status[PREC_BIT])
    else $error("single mode left precision bit set");
  a_double_bit: assert property (s_issue(OP_DOUBLE_MODE) |=> fp_status[PREC_BIT])
    else $error("double mode left precision bit clear");
  a_long_bit: assert property (s_issue(OP_LONG_INT_MODE) |=> fp_status[LONG_BIT])
    else $error("long mode left long bit clear");
  a_flag_copy: assert property (s_issue(OP_FLAG_COPY) |=>
    cpu_cc_wr && cpu_cc == $past(fp_status[3:0]))
    else $error("flag copy mismatch");
endmodule : fcm_convert_unit

// ---- bench/fcm_host_model.sv ----
// host side model: issues one command and collects its answer
module fcm_host_model
  import fcm_pkg::*;
(
  input wire logic sys_clk,         // unit clock
  input wire logic res_valid,       // result strobe
  output logic cmd_valid,           // command strobe
  output fcm_pkg::fcm_cmd_t cmd_i   // command word
);
  import fcm_pkg::*;
  initial begin
    cmd_valid = 1'h0;
    cmd_i = '0;
  end
  // held across the taking edge, answer seen half a cycle later
  task automatic issue(input fcm_cmd_t c, output logic ok);
    @(negedge sys_clk);
    cmd_i = c;
    cmd_valid = 1'h1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    cmd_i = ~c;
    ok = res_valid;
  endtask : issue
endmodule : fcm_host_model

// ---- bench/fcm_convert_unit_test.sv ----
// self-checking bench for the float convert, mode and status unit
module fcm_convert_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fcm_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic cmd_valid;
  fcm_cmd_t cmd_i;
  logic exc_set = 1'h0;
  logic [3:0] exc_code_in = 4'h0;
  logic [15:0] exc_addr_in = 16'h0000;
  logic res_valid;
  fcm_res_t res;
  logic [15:0] fp_status;
  fcm_cc_t cpu_cc;
  logic cpu_cc_wr;
  int errors = 0;
  int checks = 0;
  logic ok, z, g;
  logic [2:0] md;
  logic [7:0] x;
  logic [31:0] s, k, sv;
  logic [63:0] a, e;
  logic [31:0] kc [7] = '{32'h0000_7fff, 32'hffff_8000, 32'h0000_8000, 32'hffff_7fff,
    32'h7fff_ffff, 32'h8000_0000, 32'h0000_0000};

  always #4 sys_clk = ~sys_clk;

  fcm_host_model u_fcm_host_model (
    .sys_clk(sys_clk), .res_valid(res_valid), .cmd_valid(cmd_valid), .cmd_i(cmd_i)
  );
  fcm_convert_unit u_fcm_convert_unit (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_i(cmd_i),
    .exc_set(exc_set), .exc_code_in(exc_code_in), .exc_addr_in(exc_addr_in),
    .res_valid(res_valid), .res(res), .fp_status(fp_status),
    .cpu_cc(cpu_cc), .cpu_cc_wr(cpu_cc_wr)
  );

  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic run(input fcm_op_t op, input logic dr, input logic [31:0] sr,
    input logic [63:0] fo, input logic [63:0] av);
    u_fcm_host_model.issue(fcm_cmd_t'{op, dr, sr, fo, av}, ok);
    chk(64'(ok), 64'h1);
  endtask : run

  // integer to float, single keeps 24 significant bits
  function automatic logic [63:0] i2f(input logic [31:0] v, input logic dbl);
    logic [31:0] m;
    logic [63:0] r;
    int p;
    m = v[31] ? -v : v;
    r = 64'h0;
    p = 31;
    if (m == 32'h0) return r;
    while (!m[31]) begin
      m = m << 1;
      p--;
    end
    r[63] = v[31];
    r[62:55] = 8'(p + 129);
    r[54:24] = m[30:0];
    if (!dbl) r[31:0] = 32'h0;
    return r;
  endfunction : i2f

  initial begin
    void'($urandom(25));
    repeat (6) @(negedge sys_clk);
    rst_b = 1'h1;
    chk(fp_status, STATUS_RST);
    for (int i = 0; i < 24; i++) begin
      md = (i == 7) ? 3'h6 : 3'($urandom);
      s = (i < 7) ? kc[i] : (i == 7) ? 32'h0000_0001 : $urandom;
      run(md[0] ? OP_DOUBLE_MODE : OP_SINGLE_MODE, 1'h0, 32'h0, 64'h0, 64'h0);
      run(md[1] ? OP_LONG_INT_MODE : OP_SHORT_INT_MODE, 1'h0, 32'h0, 64'h0, 64'h0);
      chk({fp_status[PREC_BIT], fp_status[LONG_BIT]}, {md[0], md[1]});
      run(OP_INT_LOAD, md[2], s, 64'h0, 64'h0);
      k = !md[1] ? {{16{s[15]}}, s[15:0]} : md[2] ? {s[15:0], 16'h0} : s;
      e = i2f(k, md[0]);
      chk(res.acc_val, e);
      chk(fp_status[3:0], {k[31], k == 32'h0, 2'h0});
    end
    s = $urandom;
    run(OP_STATUS_LOAD, 1'h0, s, 64'h0, 64'h0);
    chk(fp_status, s[15:0]);
    run(OP_STATUS_STORE, 1'h0, 32'h0, 64'h0, 64'h0);
    chk(res.dst_val[15:0], s[15:0]);
    run(OP_FLAG_COPY, 1'h0, 32'h0, 64'h0, 64'h0);
    chk({cpu_cc_wr, cpu_cc}, {1'h1, s[3:0]});
    a = {$urandom, $urandom};
    a[62] = 1'h0;
    a[31] = 1'h1;
    run(OP_STATUS_LOAD, 1'h0, 32'h0000, 64'h0, 64'h0);
    run(OP_CONV_STORE, 1'h0, 32'h0, 64'h0, a);
    chk(64'(res.dst_words), 64'(WORDS_FOUR));
    chk(res.dst_val, {a[63:32], 32'h0});
    run(OP_STATUS_LOAD, 1'h0, 32'h00a0, 64'h0, 64'h0);
    run(OP_CONV_STORE, 1'h0, 32'h0, 64'h0, a);
    chk(res.dst_val[31:0], a[63:32]);
    chk(64'(res.dst_words), 64'(WORDS_TWO));
    run(OP_STATUS_LOAD, 1'h0, 32'h0080, 64'h0, 64'h0);
    run(OP_CONV_STORE, 1'h0, 32'h0, 64'h0, a);
    chk(res.dst_val[31:0], a[63:32] + 32'h1);
    for (int i = 0; i < 8; i++) begin
      a = {$urandom, $urandom};
      s = $urandom;
      if (i == 0) a[62:55] = EXP_BIAS;
      run(OP_EXP_LOAD, 1'h0, s, 64'h0, a);
      chk(res.acc_val[63:55], {a[63], s[7:0] + EXP_BIAS});
      run(OP_EXP_STORE, 1'h0, 32'h0, 64'h0, a);
      x = a[62:55] - EXP_BIAS;
      chk(res.dst_val[15:0], {{8{x[7]}}, x});
      chk({cpu_cc_wr, cpu_cc}, {1'h1, x[7], x == 8'h0, 2'h0});
      chk(fp_status[3:0], {x[7], x == 8'h0, 2'h0});
      a = {$urandom, $urandom};
      if (i == 1) a[62:55] = 8'h00;
      z = a[62:55] == 8'h00;
      run(OP_FLAG_TEST, 1'h0, 32'h0, a, 64'h0);
      chk({res.dst_wr, fp_status[3:0]}, {1'h0, a[63] & !z, z, 2'h0});
      run(OP_MAGNITUDE, 1'h0, 32'h0, a, 64'h0);
      chk(64'(res.dst_words), 64'(WORDS_FOUR));
      if (!z) chk(res.dst_val, {1'h0, a[62:0]});
    end
    run(OP_CLEAR, 1'h0, 32'h0, a, a);
    chk({res.dst_wr, res.dst_words, fp_status[3:0]}, {1'h1, WORDS_FOUR, 4'h4});
    chk(res.dst_val, 64'h0);
    for (int i = 0; i < 40; i++) begin
      k = (i < 7) ? kc[i] : $urandom;
      md = $urandom;
      a = i2f(k, 1'h1);
      // half bit below the binary point: must be cut, never rounded in
      if (md[0] && k != 32'h0) a[183 - a[62:55]] = 1'h1;
      if (i == 5) a[63] = 1'h0;
      g = (i != 5) && (md[1] || k[31:15] == {17{k[15]}});
      run(OP_STATUS_LOAD, 1'h0, {24'h0, 1'h1, md[1], 6'h0}, 64'h0, 64'h0);
      run(OP_INT_STORE, md[2], 32'h0, 64'h0, a);
      sv = !g ? 32'h0 : !md[1] ? {{16{k[15]}}, k[15:0]} : md[2] ? {{16{k[31]}}, k[31:16]} : k;
      if (md[1] && !md[2]) begin
        chk({res.dst_words, res.dst_val[31:0]}, {WORDS_TWO, sv});
      end else begin
        chk({res.dst_words, res.dst_val[15:0]}, {WORDS_ONE, sv[15:0]});
      end
      chk(fp_status[3:0], {sv[31], sv == 32'h0, 1'h0, !g});
    end
    @(negedge sys_clk);
    exc_code_in = $urandom;
    exc_addr_in = $urandom;
    exc_set = 1'h1;
    @(negedge sys_clk);
    exc_set = 1'h0;
    run(OP_EXCEPTION_STORE, 1'h0, 32'h0, 64'h0, 64'h0);
    chk({res.dst_words, res.dst_val[31:0]}, {WORDS_TWO, exc_addr_in, 12'h0, exc_code_in});
    run(OP_EXCEPTION_STORE, 1'h1, 32'h0, 64'h0, 64'h0);
    chk({res.dst_words, res.dst_val[15:0]}, {WORDS_ONE, 12'h0, exc_code_in});
    stop_test();
  end
endmodule : fcm_convert_unit_test
